// ### design/isb_pkg.sv
// Purpose: Constants shared by the isolated SPI pulse bridge
// Assumes: 100 MHz core clock
// Notes:   Times kept in ns, cycle counts derived from them except SCK_PULSE_CYC
package isb_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS     = 10;
	localparam int LONG_HALF_NS      = 150;
	localparam int SHORT_HALF_NS     = 50;
	localparam logic [4:0] LONG_HALF_CYC  = 5'((LONG_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [4:0] SHORT_HALF_CYC = 5'((SHORT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// Receive acceptance: half pulse at least 3/4 of nominal, inversion within 3/2
	localparam logic [4:0] SHORT_MIN_CYC = 5'(SHORT_HALF_CYC * 3 / 4);
	localparam logic [4:0] LONG_MIN_CYC  = 5'(LONG_HALF_CYC * 3 / 4);
	localparam logic [4:0] INV_MAX_CYC   = 5'(LONG_HALF_CYC * 3 / 2);
	localparam logic [4:0] SCK_PULSE_CYC = 5'd2;
	// ==========================================================
	// Symbol codes: {long, negative}
	localparam logic [1:0] SYM_SHORT_POS = 2'h0;
	localparam logic [1:0] SYM_SHORT_NEG = 2'h1;
	localparam logic [1:0] SYM_LONG_POS  = 2'h2;
	localparam logic [1:0] SYM_LONG_NEG  = 2'h3;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_WIDTH = 2;
	typedef enum logic [1:0] {
		ISB_TX_IDLE  = 2'b00,
		ISB_TX_FIRST = 2'b01,
		ISB_TX_SECOND= 2'b10
	} isb_tx_t;
	typedef enum logic [1:0] {
		ISB_RX_IDLE  = 2'b00,
		ISB_RX_FIRST = 2'b01,
		ISB_RX_SECOND= 2'b10
	} isb_rx_t;
endpackage : isb_pkg

// ### design/isb_fifo.sv
// Purpose: Small synchronous FIFO for symbols waiting to be sent
// Assumes: Single clock, synchronous active-high reset
// Notes:   Depth must be a power of two
`timescale 1ns/100ps
`default_nettype none
module isb_fifo #(
	parameter int WIDTH = 2,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             core_clk_in,
	input  wire logic             sys_rst_in,
	// Fill side
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	// Drain side
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic [WIDTH-1:0]      out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic             push;
	logic             pop;
	// Full when pointers differ only in the wrap bit
	assign in_ready_out  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
	assign out_valid_out = wr_ptr != rd_ptr;
	assign out_data_out  = mem[rd_ptr[AW-1:0]];
	assign push          = in_valid_in & in_ready_out;
	assign pop           = out_valid_out & out_ready_in;
	// Storage
	always_ff @(posedge core_clk_in) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data_in;
		end
	end
	// Pointers
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) wr_ptr <= wr_ptr + 1'b1;
			if (pop)  rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule : isb_fifo
`default_nettype wire

// ### design/isb_bridge.sv
// Purpose: Bridge between a four-wire SPI port and a bipolar pulse link
// Assumes: Comparator levels arrive as link_plus/link_minus, synchronous to core_clk_in
// Notes:   Driver levels leave as drive_pos/drive_neg; both low means zero
`timescale 1ns/100ps
`default_nettype none
module isb_bridge
	import isb_pkg::*;
(
	// Clock and reset
	input  wire logic core_clk_in,
	input  wire logic sys_rst_in,
	// Configuration
	input  wire logic role_select_in,
	input  wire logic clock_phase_in,
	input  wire logic clock_polarity_in,
	input  wire logic wake_in,
	// SPI pins, inputs and outputs with enables
	input  wire logic cs_n_in,
	output logic      cs_n_out,
	output logic      cs_n_oe_out,
	input  wire logic sck_in,
	output logic      sck_out,
	output logic      sck_oe_out,
	input  wire logic pico_in,
	output logic      pico_out,
	output logic      pico_oe_out,
	input  wire logic poci_in,
	output logic      poci_out,
	output logic      poci_oe_out,
	// Link comparators and driver
	input  wire logic link_plus_in,
	input  wire logic link_minus_in,
	output logic      drive_pos_out,
	output logic      drive_neg_out,
	output logic      tx_busy_out,
	output logic      fifo_full_out
);
	import isb_pkg::*;

	// ==========================================================
	// Pin directions
	assign cs_n_oe_out = ~role_select_in;
	assign sck_oe_out  = ~role_select_in;
	assign pico_oe_out = ~role_select_in;
	assign poci_oe_out = role_select_in;

	// ==========================================================
	// Edge detection: SPI in controller role, wake in peripheral role
	logic cs_prev;
	logic sck_prev;
	logic wake_prev;
	logic lead_edge;
	logic latch_edge;
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			cs_prev   <= 1'b1;
			sck_prev  <= 1'b0;
			wake_prev <= 1'b0;
		end else begin
			cs_prev   <= cs_n_in;
			sck_prev  <= sck_in;
			wake_prev <= wake_in;
		end
	end
	// Edge leaving idle is the first edge; its opposite the second
	assign lead_edge  = (sck_in != sck_prev) && (sck_prev == clock_polarity_in);
	assign latch_edge = (sck_in != sck_prev) && !cs_n_in
	                    && (clock_phase_in ? !lead_edge : lead_edge);

	// ==========================================================
	// Symbol requests into the FIFO
	logic       q_valid;
	logic [1:0] q_data;
	logic       q_ready;
	logic       ret_req;
	always_comb begin
		q_valid = 1'b0;
		q_data  = SYM_SHORT_NEG;
		if (role_select_in) begin
			if (cs_n_in && !cs_prev) begin
				q_valid = 1'b1;
				q_data  = SYM_LONG_POS;
			end else if (!cs_n_in && cs_prev) begin
				q_valid = 1'b1;
				q_data  = SYM_LONG_NEG;
			end else if (latch_edge) begin
				q_valid = 1'b1;
				q_data  = pico_in ? SYM_SHORT_POS : SYM_SHORT_NEG;
			end
		end else if (wake_in && !wake_prev) begin
			q_valid = 1'b1;
			q_data  = SYM_LONG_POS;
		end else if (ret_req && !poci_in) begin
			q_valid = 1'b1;
			q_data  = SYM_SHORT_NEG;
		end
	end
	assign fifo_full_out = ~q_ready;

	logic       f_valid;
	logic       f_ready;
	logic [1:0] f_data;
	isb_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk_in   (core_clk_in),
		.sys_rst_in    (sys_rst_in),
		.in_valid_in   (q_valid),
		.in_ready_out  (q_ready),
		.in_data_in    (q_data),
		.out_valid_out (f_valid),
		.out_ready_in  (f_ready),
		.out_data_out  (f_data)
	);

	// ==========================================================
	// Transmitter: two halves then zero
	isb_tx_t    tx_state;
	logic [4:0] tx_cnt;
	logic [1:0] tx_sym;
	logic [4:0] tx_len;
	assign f_ready     = (tx_state == ISB_TX_IDLE);
	assign tx_busy_out = (tx_state != ISB_TX_IDLE);
	assign tx_len      = tx_sym[1] ? LONG_HALF_CYC : SHORT_HALF_CYC;
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			tx_state <= ISB_TX_IDLE;
			tx_cnt   <= 5'h00;
			tx_sym   <= SYM_SHORT_POS;
		end else begin
			unique case (tx_state)
				ISB_TX_IDLE: begin
					if (f_valid) begin
						tx_sym   <= f_data;
						tx_cnt   <= 5'h01;
						tx_state <= ISB_TX_FIRST;
					end
				end
				ISB_TX_FIRST: begin
					if (tx_cnt == tx_len) begin
						tx_cnt   <= 5'h01;
						tx_state <= ISB_TX_SECOND;
					end else begin
						tx_cnt <= tx_cnt + 5'h01;
					end
				end
				ISB_TX_SECOND: begin
					if (tx_cnt == tx_len) begin
						tx_state <= ISB_TX_IDLE;
					end else begin
						tx_cnt <= tx_cnt + 5'h01;
					end
				end
				default: tx_state <= ISB_TX_IDLE;
			endcase
		end
	end
	// Three-level drive; never both
	always_comb begin
		drive_pos_out = 1'b0;
		drive_neg_out = 1'b0;
		if (tx_state == ISB_TX_FIRST) begin
			drive_pos_out = ~tx_sym[0];
			drive_neg_out = tx_sym[0];
		end else if (tx_state == ISB_TX_SECOND) begin
			drive_pos_out = tx_sym[0];
			drive_neg_out = ~tx_sym[0];
		end
	end

	// ==========================================================
	// Receiver: measure first half, then inversion
	isb_rx_t    rx_state;
	logic [4:0] rx_cnt;
	logic       rx_neg;
	logic [4:0] rx_first;
	logic       rx_pos_lvl;
	logic       rx_neg_lvl;
	logic       rx_done;
	logic [1:0] rx_sym;
	// Own transmission is not decoded
	assign rx_pos_lvl = link_plus_in & ~link_minus_in & ~tx_busy_out;
	assign rx_neg_lvl = link_minus_in & ~link_plus_in & ~tx_busy_out;
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			rx_state <= ISB_RX_IDLE;
			rx_cnt   <= 5'h00;
			rx_neg   <= 1'b0;
			rx_first <= 5'h00;
			rx_done  <= 1'b0;
			rx_sym   <= SYM_SHORT_POS;
		end else begin
			rx_done <= 1'b0;
			unique case (rx_state)
				ISB_RX_IDLE: begin
					if (rx_pos_lvl || rx_neg_lvl) begin
						rx_neg   <= rx_neg_lvl;
						rx_cnt   <= 5'h01;
						rx_state <= ISB_RX_FIRST;
					end
				end
				ISB_RX_FIRST: begin
					if ((rx_neg ? rx_pos_lvl : rx_neg_lvl) && rx_cnt >= SHORT_MIN_CYC && rx_cnt <= INV_MAX_CYC) begin
						rx_first <= rx_cnt;
						rx_state <= ISB_RX_SECOND;
					end else if (!(rx_neg ? rx_neg_lvl : rx_pos_lvl)) begin
						rx_state <= ISB_RX_IDLE;
					end else if (rx_cnt <= INV_MAX_CYC) begin
						rx_cnt <= rx_cnt + 5'h01;  // Saturates so an overlong half never restarts as a short one
					end
				end
				ISB_RX_SECOND: begin
					// Decision taken one cycle after the inversion: fixed delay
					rx_done  <= 1'b1;
					rx_sym   <= {(rx_first >= LONG_MIN_CYC), rx_neg};
					rx_state <= ISB_RX_IDLE;
				end
				default: rx_state <= ISB_RX_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Peripheral SPI rebuild and return sequencing
	logic       sck_act;
	logic [4:0] sck_cnt;
	logic       bit_pend;
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			cs_n_out <= 1'b1;
			pico_out <= 1'b0;
			sck_act  <= 1'b0;
			sck_cnt  <= 5'h00;
			bit_pend <= 1'b0;
			ret_req  <= 1'b0;
		end else begin
			ret_req <= 1'b0;
			if (!role_select_in && rx_done) begin
				unique case (rx_sym)
					SYM_LONG_POS: cs_n_out <= 1'b1;
					SYM_LONG_NEG: begin
						cs_n_out <= 1'b0;
						ret_req  <= 1'b1;
					end
					SYM_SHORT_POS, SYM_SHORT_NEG: begin
						pico_out <= ~rx_sym[0];
						bit_pend <= 1'b1;
					end
				endcase
			end else if (bit_pend) begin
				// PICO settled two cycles before the clock pulse reaches sck_out
				bit_pend <= 1'b0;
				sck_act  <= 1'b1;
				sck_cnt  <= 5'(SCK_PULSE_CYC + SCK_PULSE_CYC);
			end else if (sck_act) begin
				sck_cnt <= sck_cnt - 5'h01;
				if (sck_cnt == 5'h01) begin
					sck_act <= 1'b0;
					ret_req <= 1'b1;
				end
			end
		end
	end
	// Pulse is two toggles; phase 1 holds the off-idle level while selected
	logic sck_pulse;
	assign sck_pulse = sck_act && (sck_cnt > SCK_PULSE_CYC);
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			sck_out <= 1'b0;
		end else if (clock_phase_in) begin
			sck_out <= clock_polarity_in ^ (!cs_n_out && !sck_pulse);
		end else begin
			sck_out <= clock_polarity_in ^ sck_pulse;
		end
	end

	// ==========================================================
	// Controller POCI: default 1, cleared by short -1, refreshed each bit
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			poci_out <= 1'b1;
		end else if (role_select_in && rx_done && rx_sym == SYM_SHORT_NEG) begin
			poci_out <= 1'b0;
		end else if (role_select_in && (latch_edge || (cs_prev && !cs_n_in))) begin
			poci_out <= 1'b1;
		end
	end

	// ==========================================================
	// Checks
	tx_len_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		$rose(tx_busy_out) && tx_sym == SYM_LONG_NEG |-> drive_neg_out [*8])
		else $error("long half too short");
	tx_short_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		$rose(drive_pos_out) && $past(tx_state) == ISB_TX_IDLE && tx_sym == SYM_SHORT_POS
		|-> drive_pos_out [*5] ##1 drive_neg_out [*5] ##1 !drive_neg_out)
		else $error("short symbol shape wrong");
	tx_excl_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		!(drive_pos_out && drive_neg_out))
		else $error("both drives on");
	tx_sym_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		tx_state == ISB_TX_FIRST |-> drive_pos_out == !tx_sym[0])
		else $error("first half polarity wrong");
	cs_fall_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		role_select_in && !cs_n_in && cs_prev && q_ready |-> q_valid && q_data == SYM_LONG_NEG)
		else $error("select fall not queued");
	no_pos_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		!role_select_in && q_valid |-> q_data != SYM_SHORT_POS)
		else $error("peripheral short +1");
	cs_rebuild_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		!role_select_in && rx_done && rx_sym == SYM_LONG_NEG |=> !cs_n_out)
		else $error("select not lowered");
	poci_dec_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		role_select_in && rx_done && rx_sym == SYM_SHORT_NEG |=> !poci_out)
		else $error("return zero lost");
	ret_seq_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
		!role_select_in && rx_done && !rx_sym[1] |=> ##1 sck_act ##[1:8] ret_req)
		else $error("return not after clock");
	c_long_c: cover property (@(posedge core_clk_in) rx_done && rx_sym == SYM_LONG_NEG);
	c_short_c: cover property (@(posedge core_clk_in) rx_done && rx_sym == SYM_SHORT_NEG);
	c_full_c: cover property (@(posedge core_clk_in) fifo_full_out);
endmodule : isb_bridge
`default_nettype wire

// ### test/isb_far_end.sv
// Purpose: Remote pulse transceiver model facing the bridge link
// Assumes: Line levels are synchronous to the core clock
// Notes:   Decodes drive pairs and sends pulse pairs on the comparator flags
`timescale 1ns/100ps
`default_nettype none
module isb_far_end (
	// Clock
	input  wire logic core_clk_in,
	// Line driven by the bridge
	input  wire logic drive_pos_in,
	input  wire logic drive_neg_in,
	// Comparator flags towards the bridge
	output logic       link_plus_out,
	output logic       link_minus_out,
	// Decoded symbols
	output int         rx_count_out,
	output logic [1:0] rx_sym_out,
	output int         rx_half_out,
	output logic       rx_bad_out
);
	int   first_len;
	int   second_len;
	logic first_neg;
	initial begin
		{link_plus_out, link_minus_out, rx_bad_out, first_neg} = 4'h0;
		rx_sym_out = 2'h0;
		{rx_count_out, rx_half_out, first_len, second_len} = '0;
	end
	// ==========================================
	// Receive: halves must be opposite and equal, long above ten cycles
	always @(posedge core_clk_in) begin
		if (drive_pos_in | drive_neg_in) begin
			if (second_len == 0 && (first_len == 0 || drive_neg_in == first_neg)) begin
				first_neg <= drive_neg_in;
				first_len <= first_len + 1;
			end else begin
				second_len <= second_len + 1;
			end
		end else if (first_len != 0) begin
			rx_bad_out   <= rx_bad_out | (second_len != first_len);
			rx_sym_out   <= {first_len > 10, first_neg};
			rx_half_out  <= first_len;
			rx_count_out <= rx_count_out + 1;
			first_len    <= 0;
			second_len   <= 0;
		end
	end
	// ==========================================
	// Send one pair, back to null after it, so a stale level never lingers
	task automatic send_sym(input logic neg, input int half);
		link_plus_out = !neg;
		link_minus_out = neg;
		repeat (half) @(posedge core_clk_in);
		#1;
		link_plus_out = neg;
		link_minus_out = !neg;
		repeat (half) @(posedge core_clk_in);
		#1;
		link_plus_out = 1'b0;
		link_minus_out = 1'b0;
	endtask : send_sym
endmodule : isb_far_end
`default_nettype wire

// ### test/isb_bridge_tb.sv
// Purpose: Self-checking bench for the pulse bridge in both roles
// Assumes: Inputs change 1 ns after the rising clock edge
// Notes:   SPI wires resolve from the bridge enables and the bench drive
`timescale 1ns/100ps
`default_nettype none
module isb_bridge_tb;
	import isb_pkg::*;
	logic       clk = 0, rst = 1, role = 1, clock_phase = 0, clock_polarity = 0, wake = 0;
	logic       cs_n = 1, sck = 0, pico = 0, poci = 1, seen, pv;
	logic       cs_o, cs_oe, sck_o, sck_oe, pico_o, pico_oe, poci_o, poci_oe;
	logic       lp, lm, dp, dn, busy, full;
	logic [1:0] rx_sym;
	int         rx_count, rx_half, m, b, i, n, cycles = 0;
	int         miscompares = 0, samples_checked = 0;
	logic       rx_bad;
	wire        cs_w = cs_oe ? cs_o : cs_n;
	wire        sck_w = sck_oe ? sck_o : sck;
	wire        pico_w = pico_oe ? pico_o : pico;
	wire        poci_w = poci_oe ? poci_o : poci;
	initial forever #5 clk = !clk;
	isb_bridge dut_u (.core_clk_in(clk), .sys_rst_in(rst), .role_select_in(role), .clock_phase_in(clock_phase),
		.clock_polarity_in(clock_polarity), .wake_in(wake), .cs_n_in(cs_w), .cs_n_out(cs_o), .cs_n_oe_out(cs_oe),
		.sck_in(sck_w), .sck_out(sck_o), .sck_oe_out(sck_oe), .pico_in(pico_w), .pico_out(pico_o),
		.pico_oe_out(pico_oe), .poci_in(poci_w), .poci_out(poci_o), .poci_oe_out(poci_oe),
		.link_plus_in(lp), .link_minus_in(lm), .drive_pos_out(dp), .drive_neg_out(dn),
		.tx_busy_out(busy), .fifo_full_out(full));
	isb_far_end far_u (.core_clk_in(clk), .drive_pos_in(dp), .drive_neg_in(dn), .link_plus_out(lp),
		.link_minus_out(lm), .rx_count_out(rx_count), .rx_sym_out(rx_sym), .rx_half_out(rx_half),
		.rx_bad_out(rx_bad));
	// ==========================================
	// Helpers
	task tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : tick
	task check(input string what, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check
	// Bounded wait so a lost symbol cannot hang the run
	task wait_rx(input int k);
		for (int j = 0; j < 300 && rx_count < k; j++) tick(1);
	endtask : wait_rx
	task print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict
	// Cycle ceiling, several times the expected run length
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			print_verdict();
		end
	end
	// ==========================================
	// Main sequence
	initial begin
		tick(6);
		rst = 0;
		check("idle drive", {dp, dn, busy}, 0);
		check("reset poci", poci_o, 1);
		check("poci oe", {poci_oe, cs_oe, sck_oe, pico_oe}, 8);
		for (m = 0; m < 4; m++) begin
			{clock_polarity, clock_phase} = m[1:0];
			sck = m[1];
			pico = m[0];
			tick(3);
			n = rx_count;
			cs_n = 0;
			wait_rx(n + 1);
			check("cs fall sym", rx_sym, SYM_LONG_NEG);
			check("long half", rx_half, LONG_HALF_CYC);
			sck = !sck;
			tick(25);
			sck = !sck;
			tick(40);
			check("bit count", rx_count, n + 2);
			check("bit sym", rx_sym, m[0] ? SYM_SHORT_POS : SYM_SHORT_NEG);
			check("short half", rx_half, SHORT_HALF_CYC);
			cs_n = 1;
			wait_rx(n + 3);
			check("cs rise sym", rx_sym, SYM_LONG_POS);
		end
		{clock_polarity, clock_phase, sck} = 3'h0;
		cs_n = 0;
		wait_rx(rx_count + 1);
		far_u.send_sym(1'b1, SHORT_HALF_CYC);
		tick(4);
		check("return zero", poci_o, 0);
		sck = 1;
		tick(3);
		check("absent reads one", poci_o, 1);
		tick(30);
		$display("controller test done");
		n = rx_count;
		seen = 0;
		for (i = 0; i < 30; i++) begin
			sck = !sck;
			tick(1);
			sck = !sck;
			tick(1);
			seen = seen | full;
		end
		wait_rx(n + 30);
		check("fifo refused", seen, 1);
		check("fifo kept", (rx_count - n >= 16) && (rx_count - n < 30), 1);
		check("drained", {busy, full}, 0);
		cs_n = 1;
		wait_rx(rx_count + 1);
		$display("fifo test done");
		role = 0;
		poci = 0;
		tick(3);
		check("peripheral oe", {poci_oe, cs_oe, sck_oe, pico_oe}, 7);
		far_u.send_sym(1'b1, 2);
		tick(5);
		check("runt ignored", cs_o, 1);
		n = rx_count;
		far_u.send_sym(1'b1, 27);
		tick(20);
		check("late ignored", rx_count, n);
		n = rx_count;
		far_u.send_sym(1'b1, LONG_HALF_CYC);
		tick(3);
		check("cs low", cs_o, 0);
		wait_rx(n + 1);
		check("initial bit", rx_sym, SYM_SHORT_NEG);
		for (b = 1; b >= 0; b--) begin
			poci = b[0];
			n = rx_count;
			seen = 0;
			fork
				far_u.send_sym(!b[0], SHORT_HALF_CYC);
			join_none
			for (i = 0; i < 45; i++) begin
				if (sck_o === 1'b1 && !seen) pv = pico_o;
				if (sck_o === 1'b1) seen = 1;
				tick(1);
			end
			check("sck pulse", seen, 1);
			check("pico at sck", pv, b[0]);
			check("return count", rx_count, n + 1 - b);
			check("return sym", rx_sym, SYM_SHORT_NEG);
		end
		n = rx_count;
		far_u.send_sym(1'b0, LONG_HALF_CYC);
		tick(3);
		check("cs high", cs_o, 1);
		clock_phase = 1;
		tick(30);
		check("no cs return", rx_count, n);
		far_u.send_sym(1'b1, LONG_HALF_CYC);
		tick(3);
		check("sck off idle", sck_o, 1);
		tick(30);
		far_u.send_sym(1'b0, LONG_HALF_CYC);
		tick(3);
		check("sck back idle", sck_o, 0);
		n = rx_count;
		wake = 1;
		wait_rx(n + 1);
		check("wake sym", rx_sym, SYM_LONG_POS);
		check("pairs symmetric", rx_bad, 0);
		$display("peripheral test done");
		print_verdict();
	end
endmodule : isb_bridge_tb
`default_nettype wire
